// *** bench/abrm_host.sv ***
// Purpose: APB host model driving the bias and monitor register bank
// Assumes: Single clock; one transfer at a time
// Notes:   Released write data is inverted so stale values never look valid
module abrm_host
(
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  // Request held until pready is sampled high at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // No cycle count assumed; only the bench watchdog ends a hung wait
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : xfer
endmodule : abrm_host

// *** bench/tb_adc_bias_reference_monitor_regs.sv ***
// Purpose: Self-checking bench for the bias and monitor register bank
// Assumes: One wait state is not relied on; host waits for pready
// Notes:   Random values from a fixed seed, all monitor and reference codes swept
`include "abrm_map.svh"

module tb_adc_bias_reference_monitor_regs;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0, presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic ext = 1'b0, conv = 1'b0, slp = 1'b0, start = 1'b0, rerr;
  logic [2:0] gain = 3'h0, pos = 3'h0, neg = 3'h0;
  logic [7:0] b, m;
  abrm_pkg::abrm_front_end_t fe;
  int error_cnt = 0, n_tests = 0, seed = 21;

  always #5 pclk = ~pclk;

  abrm_regs abrm_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_in_use(ext), .conversion_active(conv), .sleep_command(slp), .start_pin(start),
    .programmed_gain(gain), .positive_input_select(pos), .negative_input_select(neg), .front_end(fe));

  abrm_host abrm_host_i (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    abrm_host_i.xfer(w, a, d, s, rdat, rerr);
  endtask : acc

  function automatic abrm_pkg::abrm_front_end_t expect_fe(input logic [7:0] bv, input logic [7:0] mv);
    abrm_pkg::abrm_front_end_t e;
    logic nrm;
    nrm = (mv[2:0] == `ABRM_MON_NORMAL);
    e.src = abrm_pkg::abrm_src_t'(mv[2:0]);
    e.inputs_connected = nrm;
    e.positive_input_select = pos;
    e.negative_input_select = neg;
    e.bias_enable = nrm ? bv : 8'h00;
    e.ref_select_active = nrm;
    e.ref_select = mv[4:3];
    e.drive_ext_ref0_pins = nrm && (mv[4:3] == `ABRM_RSEL_INT_PINS);
    e.ref_power_on = mv[6] ? (conv & ~slp & start) : mv[5];
    e.gain = (mv[2:0] > `ABRM_MON_OFFSET) ? `ABRM_GAIN_UNITY : gain;
    return e;
  endfunction : expect_fe

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #200us;
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    ext <= 1'b1;
    acc(1'b0, `ABRM_ADDR_BIAS, 32'h0, 4'h1);
    check(rdat, 32'h0000_0000);
    acc(1'b0, `ABRM_ADDR_MUX_CONTROL_ONE, 32'h0, 4'h1);
    check(rdat, 32'h0000_0080);
    check(32'(fe), 32'(expect_fe(8'h00, 8'h00)));
    // Codes walk 7 then 0, so gain restore is seen at every wrap
    for (int i = 0; i < 64; i++)
    begin
      b = 8'($random(seed));
      m = 8'($random(seed));
      m[6:5] = 2'(i >> 3);
      m[2:0] = 3'(i);
      if (m[2:1] == 2'h2)
        m[6:5] = `ABRM_REFC_ON;
      ext <= 1'($random(seed));
      conv <= 1'($random(seed));
      slp <= 1'($random(seed));
      start <= 1'($random(seed));
      gain <= 3'($random(seed));
      pos <= 3'($random(seed));
      neg <= 3'($random(seed));
      acc(1'b1, `ABRM_ADDR_BIAS, {24'h0, b}, 4'hF);
      acc(1'b1, `ABRM_ADDR_MUX_CONTROL_ONE, {24'h0, m}, 4'h1);
      acc(1'b0, `ABRM_ADDR_MUX_CONTROL_ONE, 32'h0, 4'h1);
      check(rdat, {24'h0, ext, m[6:0]});
      acc(1'b0, `ABRM_ADDR_BIAS, 32'h0, 4'h1);
      check(rdat, {24'h0, b});
      repeat (2) @(posedge pclk);
      check(32'(fe), 32'(expect_fe(b, m)));
    end
    acc(1'b1, `ABRM_ADDR_BIAS, ~{24'h0, b}, 4'hE);
    acc(1'b0, `ABRM_ADDR_BIAS, 32'h0, 4'h1);
    check(rdat, {24'h0, b});
    acc(1'b1, 12'h00C, 32'hFF, 4'hF);
    check({31'h0, rerr}, 32'h1);
    acc(1'b0, 12'h00C, 32'h0, 4'h1);
    check({rdat[30:0], rerr}, 32'h1);
    // Mid-run reset must bring both registers back to defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, `ABRM_ADDR_MUX_CONTROL_ONE, 32'h0, 4'h1);
    check(rdat, {24'h0, ext, 7'h00});
    acc(1'b0, `ABRM_ADDR_BIAS, 32'h0, 4'h1);
    check(rdat, 32'h0000_0000);
    check(32'(fe), 32'(expect_fe(8'h00, 8'h00)));
    report_and_stop();
  end
endmodule : tb_adc_bias_reference_monitor_regs

// *** common/abrm_map.svh ***
// Purpose: Offsets, field positions, reset values and codes of the bias and monitor registers
// Assumes: Register index times four gives the APB byte address
// Notes:   Definitions only
`ifndef ABRM_MAP_SVH
`define ABRM_MAP_SVH

`define ABRM_IDX_BIAS        4'h1
`define ABRM_IDX_MUX_CONTROL_ONE        4'h2
`define ABRM_ADDR_BIAS       {`ABRM_IDX_BIAS, 2'h0}
`define ABRM_ADDR_MUX_CONTROL_ONE       {`ABRM_IDX_MUX_CONTROL_ONE, 2'h0}

`define ABRM_MUX_CONTROL_ONE_CLK_BIT    7
`define ABRM_MUX_CONTROL_ONE_REFC_HI    6
`define ABRM_MUX_CONTROL_ONE_REFC_LO    5
`define ABRM_MUX_CONTROL_ONE_RSEL_HI    4
`define ABRM_MUX_CONTROL_ONE_RSEL_LO    3
`define ABRM_MUX_CONTROL_ONE_MON_HI     2
`define ABRM_MUX_CONTROL_ONE_MON_LO     0

`define ABRM_RST_BIAS        8'h00
`define ABRM_RST_REFC        2'h0
`define ABRM_RST_RSEL        2'h0
`define ABRM_RST_MON         3'h0

`define ABRM_REFC_OFF        2'h0
`define ABRM_REFC_ON         2'h1
`define ABRM_RSEL_INT_PINS   2'h3
`define ABRM_MON_NORMAL      3'h0
`define ABRM_MON_OFFSET      3'h1
`define ABRM_GAIN_UNITY      3'h0

`endif

// *** common/abrm_pkg.sv ***
// Purpose: Types shared by the bias and monitor register bank
// Assumes: Nothing beyond the map header
// Notes:   Source enum order follows the monitor select codes
package abrm_pkg;

  typedef enum logic [2:0] {
    ABRM_SRC_NORMAL,
    ABRM_SRC_MID_SUPPLY,
    ABRM_SRC_REF_FULL,
    ABRM_SRC_TEMP_DIODE,
    ABRM_SRC_REF1_QUARTER,
    ABRM_SRC_REF0_QUARTER,
    ABRM_SRC_AVDD_QUARTER,
    ABRM_SRC_DVDD_QUARTER
  } abrm_src_t;

  typedef struct packed {
    abrm_src_t src;
    logic      inputs_connected;
    logic      gain_forced;
  } abrm_route_t;

  typedef struct packed {
    abrm_src_t  src;
    logic       inputs_connected;
    logic [2:0] positive_input_select;
    logic [2:0] negative_input_select;
    logic [7:0] bias_enable;
    logic       ref_select_active;
    logic [1:0] ref_select;
    logic       drive_ext_ref0_pins;
    logic       ref_power_on;
    logic [2:0] gain;
  } abrm_front_end_t;

endpackage : abrm_pkg

// *** rtl/abrm_regs.sv ***
// Purpose: APB register bank for input bias enables and the reference and monitor control
// Assumes: All inputs synchronous to pclk; master keeps the request until pready
// Notes:   Every access takes two access-phase cycles; front end outputs lag one cycle
`include "abrm_map.svh"

module abrm_regs
#(
  parameter int ADDR_W     = 12,
  parameter int NUM_INPUTS = 8
)
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output      logic [31:0]              prdata,
  output      logic                     pready,
  output      logic                     pslverr,
  input  wire logic                     ext_clock_in_use,
  input  wire logic                     conversion_active,
  input  wire logic                     sleep_command,
  input  wire logic                     start_pin,
  input  wire logic [2:0]               programmed_gain,
  input  wire logic [2:0]               positive_input_select,
  input  wire logic [2:0]               negative_input_select,
  output      abrm_pkg::abrm_front_end_t front_end
);

  logic [NUM_INPUTS-1:0]     input_bias_enable;
  logic [1:0]                internal_ref_control;
  logic [1:0]                ref_select;
  logic [2:0]                system_monitor_select;
  logic                      clock_source_status;
  logic                      sel_bias;
  logic                      sel_mux_control_one;
  logic                      mapped;
  logic                      access_first;
  logic                      access_done;
  logic                      write_ok;
  logic [7:0]                read_value;
  logic                      monitor_normal;
  abrm_pkg::abrm_route_t     route;
  abrm_pkg::abrm_front_end_t next_front_end;

  // Decode and APB handshake
  assign sel_bias     = paddr == ADDR_W'(`ABRM_ADDR_BIAS);
  assign sel_mux_control_one     = paddr == ADDR_W'(`ABRM_ADDR_MUX_CONTROL_ONE);
  assign mapped       = sel_bias | sel_mux_control_one;
  assign access_first = psel & penable & ~pready;
  assign access_done  = psel & penable & pready;
  // Low lane only; a write without it is dropped silently
  assign write_ok     = access_done & pwrite & mapped & pstrb[0];

  always_comb
  begin
    read_value = 8'h00;
    if (sel_bias)
    begin
      read_value = 8'(input_bias_enable);
    end
    else if (sel_mux_control_one)
    begin
      read_value = {clock_source_status, internal_ref_control, ref_select, system_monitor_select};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= access_first;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (access_first)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, read_value};
      pslverr <= ~mapped;
    end
    else if (pready)
    begin
      pslverr <= 1'b0;
    end
  end

  // Sampled each cycle so a read shows the present clock source
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_source_status <= 1'b0;
    end
    else
    begin
      clock_source_status <= ext_clock_in_use;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      input_bias_enable <= NUM_INPUTS'(`ABRM_RST_BIAS);
    end
    else if (write_ok && sel_bias)
    begin
      input_bias_enable <= pwdata[NUM_INPUTS-1:0];
    end
  end

  // Status bit is not stored, so writes to it have no effect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      internal_ref_control  <= `ABRM_RST_REFC;
      ref_select            <= `ABRM_RST_RSEL;
      system_monitor_select <= `ABRM_RST_MON;
    end
    else if (write_ok && sel_mux_control_one)
    begin
      internal_ref_control  <= pwdata[`ABRM_MUX_CONTROL_ONE_REFC_HI:`ABRM_MUX_CONTROL_ONE_REFC_LO];
      ref_select            <= pwdata[`ABRM_MUX_CONTROL_ONE_RSEL_HI:`ABRM_MUX_CONTROL_ONE_RSEL_LO];
      system_monitor_select <= pwdata[`ABRM_MUX_CONTROL_ONE_MON_HI:`ABRM_MUX_CONTROL_ONE_MON_LO];
    end
  end

  abrm_route u_route
  (
    .code  (system_monitor_select),
    .route (route)
  );

  assign monitor_normal = system_monitor_select == `ABRM_MON_NORMAL;

  always_comb
  begin
    next_front_end.src                   = route.src;
    next_front_end.inputs_connected      = route.inputs_connected;
    next_front_end.positive_input_select = positive_input_select;
    next_front_end.negative_input_select = negative_input_select;
    next_front_end.bias_enable           = monitor_normal ? 8'(input_bias_enable) : 8'h00;
    next_front_end.ref_select_active     = monitor_normal;
    next_front_end.ref_select            = ref_select;
    next_front_end.drive_ext_ref0_pins   = monitor_normal && (ref_select == `ABRM_RSEL_INT_PINS);
    // Reference monitors and excitation sources rely on software enabling the reference
    case (internal_ref_control)
      `ABRM_REFC_OFF: next_front_end.ref_power_on = 1'b0;
      `ABRM_REFC_ON:  next_front_end.ref_power_on = 1'b1;
      default:        next_front_end.ref_power_on = conversion_active & ~sleep_command & start_pin;
    endcase
    next_front_end.gain = route.gain_forced ? `ABRM_GAIN_UNITY : programmed_gain;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      front_end <= '0;
    end
    else
    begin
      front_end <= next_front_end;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_access;
    psel && penable && !pready;
  endsequence

  sequence s_answer;
    pready ##1 !pready;
  endsequence

  sequence s_bias_write;
    psel && penable && pready && pwrite && sel_bias && pstrb[0] && monitor_normal && !sel_mux_control_one;
  endsequence

  sequence s_mux_control_one_write;
    psel && penable && pready && pwrite && sel_mux_control_one && pstrb[0];
  endsequence

  chk_apb_answer: assert property (s_access |=> s_answer)
    else $error("pready not a single pulse after access");

  chk_apb_unmapped: assert property (s_access and !mapped |=> pready && pslverr)
    else $error("unmapped access not flagged");

  chk_bias_applied: assert property (s_bias_write |=> ##1
                                     (!monitor_normal || front_end.bias_enable == $past(pwdata[7:0], 2)))
    else $error("bias write not applied to front end");

  chk_clock_source_status_read: assert property (s_access and (sel_mux_control_one && !pwrite) |=>
                                     prdata[7] == $past(ext_clock_in_use, 2))
    else $error("clock status read mismatch");

  chk_mux_control_one_update: assert property (s_mux_control_one_write |=>
                                    system_monitor_select == $past(pwdata[2:0]) &&
                                    ref_select == $past(pwdata[4:3]) &&
                                    internal_ref_control == $past(pwdata[6:5]))
    else $error("mux control write incomplete");

  chk_ref_off: assert property (internal_ref_control == 2'h0 |=> !front_end.ref_power_on)
    else $error("reference on while forced off");

  chk_ref_on: assert property (internal_ref_control == 2'h1 |=> front_end.ref_power_on)
    else $error("reference off while forced on");

  chk_ref_follow: assert property (internal_ref_control[1] |=>
                                   front_end.ref_power_on ==
                                   $past(conversion_active && !sleep_command && start_pin))
    else $error("reference does not follow conversion state");

  chk_ref_pins: assert property (front_end.drive_ext_ref0_pins |->
                                 front_end.ref_select_active && front_end.ref_select == 2'h3)
    else $error("reference pins driven without internal select");

  chk_monitor_override: assert property (system_monitor_select != 3'h0 |=>
                                         front_end.bias_enable == 8'h00 && !front_end.inputs_connected &&
                                         !front_end.ref_select_active)
    else $error("monitor code does not override selections");

  chk_monitor_route: assert property (##1 front_end.src == abrm_pkg::abrm_src_t'($past(system_monitor_select)))
    else $error("monitor route does not match code");

  chk_gain_forced: assert property (system_monitor_select >= 3'h2 |=> front_end.gain == 3'h0)
    else $error("gain not forced to unity");

  chk_gain_restore: assert property (system_monitor_select < 3'h2 |=>
                                     front_end.gain == $past(programmed_gain))
    else $error("programmed gain not restored");

endmodule : abrm_regs

// *** rtl/abrm_route.sv ***
// Purpose: Decode of the system monitor select code into a converter input route
// Assumes: Pure combinational, code comes from a register
// Notes:   Only the normal code leaves the analog inputs connected
module abrm_route
(
  input  wire logic [2:0]          code,
  output abrm_pkg::abrm_route_t    route
);

  always_comb
  begin
    route.inputs_connected = 1'b0;
    route.gain_forced      = 1'b1;
    case (code)
      3'h0:
      begin
        route.src              = abrm_pkg::ABRM_SRC_NORMAL;
        route.inputs_connected = 1'b1;
        route.gain_forced      = 1'b0;
      end
      3'h1:
      begin
        route.src         = abrm_pkg::ABRM_SRC_MID_SUPPLY;
        route.gain_forced = 1'b0;
      end
      3'h2:    route.src = abrm_pkg::ABRM_SRC_REF_FULL;
      3'h3:    route.src = abrm_pkg::ABRM_SRC_TEMP_DIODE;
      3'h4:    route.src = abrm_pkg::ABRM_SRC_REF1_QUARTER;
      3'h5:    route.src = abrm_pkg::ABRM_SRC_REF0_QUARTER;
      3'h6:    route.src = abrm_pkg::ABRM_SRC_AVDD_QUARTER;
      3'h7:    route.src = abrm_pkg::ABRM_SRC_DVDD_QUARTER;
      default: route.src = abrm_pkg::ABRM_SRC_NORMAL;
    endcase
  end

endmodule : abrm_route
